// ---- verilog/swl_pkg.sv ----
// swl_pkg: constants, states and carrier types of the single-wire sensor slave link
// assumes a 250 MHz system clock; all times are converted to cycle counts here
package swl_pkg;
   localparam int CLK_MHZ = 250;
   // times in microseconds, as specified for the line
   localparam int T_RESET_US = 480;
   localparam int T_PD_WAIT_US = 30; // inside 15..60
   localparam int T_PD_LOW_US = 120; // inside 60..240
   localparam int T_SAMPLE_US = 30; // inside 15..60
   localparam int T_RDVALID_US = 15;
   // cycle counts derived from the times
   localparam int C_RESET = T_RESET_US * CLK_MHZ;
   localparam int C_PD_WAIT = T_PD_WAIT_US * CLK_MHZ;
   localparam int C_PD_LOW = T_PD_LOW_US * CLK_MHZ;
   localparam int C_SAMPLE = T_SAMPLE_US * CLK_MHZ;
   localparam int C_RDVALID = T_RDVALID_US * CLK_MHZ;
   localparam int C_RELOAD = 64; // duration of a reload from the nonvolatile store
   localparam int CNT_W = 18;
   // function and addressing command codes
   localparam logic [7:0] CMD_CONVERT = 8'h44;
   localparam logic [7:0] CMD_STORE = 8'h4E;
   localparam logic [7:0] CMD_DUMP = 8'hBE;
   localparam logic [7:0] CMD_SAVE = 8'h48;
   localparam logic [7:0] CMD_RELOAD = 8'hB8;
   localparam logic [7:0] CMD_SKIP_ADDR = 8'hCC;
   localparam logic [3:0] SP_BYTES = 4'h9;
   localparam logic [1:0] STORE_BYTES = 2'h3;
   // scratchpad reset values
   localparam logic [7:0] TEMP_LSB_RST = 8'h50;
   localparam logic [7:0] TEMP_MSB_RST = 8'h05;
   localparam logic [7:0] CFG_RST = 8'h7F;
   typedef enum logic [3:0] {
      SWL_IDLE, SWL_PD_WAIT, SWL_PD_LOW, SWL_ADDR, SWL_FUNC,
      SWL_STORE, SWL_DUMP, SWL_RELOAD_ST, SWL_BUSY, SWL_HALT
   } swl_state_t;
   // settings held in the nonvolatile store
   typedef struct packed {
      logic [7:0] th;
      logic [7:0] tl;
      logic [7:0] cfg;
   } swl_nv_t;
   typedef struct packed {
      swl_state_t st;
      logic [CNT_W-1:0] low_cnt;
      logic [CNT_W-1:0] cnt;
      logic slot_on;
      logic line_d;
      logic [7:0] sh;
      logic [2:0] bitn;
      logic [3:0] byten;
      swl_nv_t sp;
      swl_nv_t nv;
      logic [7:0] rl_cnt;
      logic pullup_req;
      logic drive_low;
      logic [1:0] buf_n;
      logic [7:0] buf0;
      logic [7:0] buf1;
      logic [7:0] out_byte;
      logic out_valid;
   } swl_state_s_t;
endpackage

// ---- verilog/swl_link.sv ----
// swl_link: slave side of a single open-drain wire to a temperature sensor
// assumes the line is already synchronous to CLK; wire level is resolved outside
`timescale 1ns/1ps
//Contract
//- reload command copies nonvolatile thresholds and config into scratchpad bytes two to four
//- after reload, read slots answer 0 while running, 1 when finished
//- reload runs automatically at power-up, no command needed
//- dump command sends nine scratchpad bytes ending with CRC
//- reset pulse aborts any transmission and starts a new initialization
//- store command takes three bytes into scratchpad bytes two, three, four
//- save command copies thresholds and config into nonvolatile memory
//- only the presence pulse is device initiated; no self-started slots
//- presence: wait 15-60 us after rise, then drive low 60-240 us
//- every time slot carries exactly one bit
//- device samples 15-60 us after slot falling edge, high is one
//- device sends only in read slots after dump or reload
//- device sends one by releasing, zero by pulling low, released by slot end
//- read bit held valid for 15 us after starting edge
//- line low longer than 480 us resets protocol state
//- only initialization, addressing, function order is honoured
//- dump starts at byte zero LSB, each byte LSB first
module swl_link
   import swl_pkg::*;
(
   input wire logic CLK, // 250 MHz system clock
   input wire logic SRST, // synchronous reset, active high
   input wire logic DQ_IN, // level seen on the data line
   output logic DQ_OUT, // driven level, always low
   output logic DQ_OE, // high while pulling the line low
   output logic STRONG_PULLUP_REQ, // conversion or save in progress
   output logic [7:0] RX_BYTE, // byte received from master
   output logic RX_VALID, // RX_BYTE held valid
   input wire logic RX_READY // consumer takes RX_BYTE
);
   swl_state_s_t s_reg, s_next;
   logic fall, rise, samp, tx_bit, rd_bit;
   logic [7:0] sp_byte;
   logic [7:0] crc_v;

   // crc over scratchpad bytes 0..7, polynomial x8+x5+x4+1
   function automatic logic [7:0] crc8(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (c[0] ^ d[i]) begin
            c = (c >> 1) ^ 8'h8C;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   assign crc_v = crc8({8'h10, 8'hFF, 8'hFF, s_reg.sp.cfg, s_reg.sp.tl, s_reg.sp.th,
                        TEMP_MSB_RST, TEMP_LSB_RST});
   // scratchpad byte selected by the dump position
   always_comb begin
      unique case (s_reg.byten)
         4'h0: sp_byte = TEMP_LSB_RST;
         4'h1: sp_byte = TEMP_MSB_RST;
         4'h2: sp_byte = s_reg.sp.th;
         4'h3: sp_byte = s_reg.sp.tl;
         4'h4: sp_byte = s_reg.sp.cfg;
         4'h5: sp_byte = 8'hFF;
         4'h6: sp_byte = 8'hFF;
         4'h7: sp_byte = 8'h10;
         default: sp_byte = crc_v;
      endcase
   end

   assign fall = s_reg.line_d & ~DQ_IN;
   assign rise = ~s_reg.line_d & DQ_IN;
   assign samp = s_reg.slot_on && s_reg.cnt == CNT_W'(C_SAMPLE);
   assign tx_bit = sp_byte[s_reg.bitn];
   assign rd_bit = (s_reg.st == SWL_DUMP) ? tx_bit : (s_reg.rl_cnt == 8'h00);

   // next-state logic for the whole link
   always_comb begin
      s_next = s_reg;
      s_next.line_d = DQ_IN;
      // low-time counter for reset detection
      if (DQ_IN) begin
         s_next.low_cnt = '0;
      end else if (s_reg.low_cnt != CNT_W'(C_RESET)) begin
         s_next.low_cnt = s_reg.low_cnt + 1'b1;
      end
      if (s_reg.rl_cnt != 8'h00) begin
         s_next.rl_cnt = s_reg.rl_cnt - 1'b1;
         if (s_reg.rl_cnt == 8'h01) begin
            s_next.sp = s_reg.nv;
         end
      end
      // slot timer, started only by a master falling edge
      if (fall && s_reg.st != SWL_PD_LOW) begin
         s_next.slot_on = 1'b1;
         s_next.cnt = '0;
      end else if (s_reg.slot_on) begin
         s_next.cnt = s_reg.cnt + 1'b1;
         if (s_reg.cnt == CNT_W'(C_SAMPLE)) begin
            s_next.slot_on = 1'b0;
         end
      end
      // read-slot driving: low bit held 15 us after the edge, then released
      if (fall && (s_reg.st == SWL_DUMP || s_reg.st == SWL_RELOAD_ST) && !rd_bit) begin
         s_next.drive_low = 1'b1;
      end else if (s_reg.st != SWL_PD_LOW && s_reg.cnt == CNT_W'(C_RDVALID)) begin
         s_next.drive_low = 1'b0;
      end
      // rx buffer drain
      if (s_reg.out_valid && RX_READY) begin
         s_next.out_valid = 1'b0;
      end
      if (!s_next.out_valid && s_reg.buf_n != 2'd0) begin
         s_next.out_byte = s_reg.buf0;
         s_next.out_valid = 1'b1;
         s_next.buf0 = s_reg.buf1;
         s_next.buf_n = s_reg.buf_n - 2'd1;
      end
      unique case (s_reg.st)
         SWL_PD_WAIT: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            s_next.slot_on = 1'b0;
            if (s_reg.cnt == CNT_W'(C_PD_WAIT)) begin
               s_next.st = SWL_PD_LOW;
               s_next.drive_low = 1'b1;
               s_next.cnt = '0;
            end
         end
         SWL_PD_LOW: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == CNT_W'(C_PD_LOW)) begin
               s_next.drive_low = 1'b0;
               s_next.st = SWL_ADDR;
               s_next.bitn = '0;
               s_next.cnt = '0;
            end
         end
         SWL_ADDR, SWL_FUNC, SWL_STORE: begin
            if (samp) begin
               s_next.sh = {DQ_IN, s_reg.sh[7:1]};
               s_next.bitn = s_reg.bitn + 3'd1;
               if (s_reg.bitn == 3'd7) begin
                  if (s_reg.st == SWL_ADDR) begin
                     // only the skip-address step is decoded; others wait for reset
                     s_next.st = ({DQ_IN, s_reg.sh[7:1]} == CMD_SKIP_ADDR) ? SWL_FUNC
                                 : SWL_HALT;
                  end else if (s_reg.st == SWL_FUNC) begin
                     s_next.byten = '0;
                     unique case ({DQ_IN, s_reg.sh[7:1]})
                        CMD_CONVERT: begin
                           s_next.st = SWL_BUSY;
                           s_next.pullup_req = 1'b1;
                        end
                        CMD_SAVE: begin
                           s_next.nv = s_reg.sp;
                           s_next.st = SWL_BUSY;
                           s_next.pullup_req = 1'b1;
                        end
                        CMD_STORE: s_next.st = SWL_STORE;
                        CMD_DUMP: s_next.st = SWL_DUMP;
                        CMD_RELOAD: begin
                           s_next.st = SWL_RELOAD_ST;
                           s_next.rl_cnt = 8'(C_RELOAD);
                        end
                        default: s_next.st = SWL_HALT;
                     endcase
                  end else begin
                     // store bytes: th, tl, cfg; each also pushed to the buffer while it has room
                     unique case (s_reg.byten[1:0])
                        2'd0: s_next.sp.th = {DQ_IN, s_reg.sh[7:1]};
                        2'd1: s_next.sp.tl = {DQ_IN, s_reg.sh[7:1]};
                        default: s_next.sp.cfg = {DQ_IN, s_reg.sh[7:1]};
                     endcase
                     // room is judged after this cycle's drain, so a byte taken now frees a slot
                     if (s_next.buf_n != 2'd2) begin
                        if (s_next.buf_n == 2'd0) s_next.buf0 = {DQ_IN, s_reg.sh[7:1]};
                        else s_next.buf1 = {DQ_IN, s_reg.sh[7:1]};
                        s_next.buf_n = s_next.buf_n + 2'd1;
                     end
                     s_next.byten = s_reg.byten + 4'd1;
                     if (s_reg.byten[1:0] == STORE_BYTES - 2'd1) begin
                        s_next.st = SWL_HALT;
                     end
                  end
               end
            end
         end
         SWL_DUMP: begin
            if (samp) begin
               s_next.bitn = s_reg.bitn + 3'd1;
               if (s_reg.bitn == 3'd7) begin
                  s_next.byten = s_reg.byten + 4'd1;
                  if (s_reg.byten == SP_BYTES - 4'd1) begin
                     s_next.st = SWL_HALT;
                  end
               end
            end
         end
         default: ;
      endcase
      // a rise after a long low is a reset pulse; it overrides everything
      if (rise && s_reg.low_cnt == CNT_W'(C_RESET)) begin
         s_next.st = SWL_PD_WAIT;
         s_next.cnt = '0;
         s_next.drive_low = 1'b0;
         s_next.pullup_req = 1'b0;
         s_next.bitn = '0;
      end else if (s_reg.low_cnt == CNT_W'(C_RESET)) begin
         s_next.st = SWL_IDLE;
         s_next.drive_low = 1'b0;
         s_next.pullup_req = 1'b0;
      end
   end

   // state register; power-up reload starts from reset
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_reg <= '0;
         s_reg.st <= SWL_IDLE;
         s_reg.line_d <= 1'b1;
         s_reg.sp <= '{th: 8'h00, tl: 8'h00, cfg: CFG_RST};
         s_reg.nv <= '{th: 8'h00, tl: 8'h00, cfg: CFG_RST};
         s_reg.rl_cnt <= 8'(C_RELOAD);
      end else begin
         s_reg <= s_next;
      end
   end

   assign DQ_OUT = 1'b0;
   assign DQ_OE = s_reg.drive_low;
   assign STRONG_PULLUP_REQ = s_reg.pullup_req;
   assign RX_BYTE = s_reg.out_byte;
   assign RX_VALID = s_reg.out_valid;
endmodule

// ---- dv/swl_link_assertions.sv ----
// swl_link_assertions: timing checks on the sensor link ports
// assumes the bench feeds the resolved wire back on DQ_IN
`timescale 1ns/1ps
module swl_link_assertions
   import swl_pkg::*;
(
   input wire logic CLK, // system clock
   input wire logic SRST, // sync reset
   input wire logic DQ_IN, // line level
   input wire logic DQ_OUT, // driven level
   input wire logic DQ_OE, // pull enable
   input wire logic STRONG_PULLUP_REQ, // pullup wanted
   input wire logic [7:0] RX_BYTE, // received byte
   input wire logic RX_VALID, // byte valid
   input wire logic RX_READY // byte taken
);
   int low_n, fall_n, rise_n, oe_n;
   logic dq_d, in_init;
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // line event counters; in_init spans the reset rise to the end of presence
   always_ff @(posedge CLK) begin
      dq_d <= DQ_IN;
      low_n <= DQ_IN ? 0 : low_n + 1;
      fall_n <= (dq_d && !DQ_IN) ? 0 : fall_n + 1;
      oe_n <= DQ_OE ? oe_n + 1 : 0;
      rise_n <= rise_n + 1;
      if (SRST || (!DQ_OE && oe_n > 0)) begin
         in_init <= 1'b0;
      end else if (!dq_d && DQ_IN && low_n >= C_RESET) begin
         in_init <= 1'b1;
         rise_n <= 0;
      end
   end
   sequence s_rx_wait;
      RX_VALID && !RX_READY;
   endsequence
   sequence s_long_low;
      low_n == C_RESET + 4;
   endsequence
   a_out_low: assert property (
      DQ_OE |-> !DQ_OUT && !DQ_IN) else $error("device drive is not low");
   a_pd_start: assert property (
      in_init && $rose(DQ_OE) |-> rise_n >= 15 * CLK_MHZ && rise_n <= 60 * CLK_MHZ)
      else $error("presence start out of range");
   a_pd_length: assert property (
      in_init && $fell(DQ_OE) |-> oe_n >= 60 * CLK_MHZ && oe_n <= 240 * CLK_MHZ)
      else $error("presence length out of range");
   a_slot_only: assert property (
      !in_init && $rose(DQ_OE) |-> fall_n <= 4) else $error("device started a slot");
   a_read_valid: assert property (
      !in_init && DQ_OE |-> fall_n <= 15 * CLK_MHZ + 2) else $error("read bit held too long");
   a_pullup_quiet: assert property (
      STRONG_PULLUP_REQ |-> !DQ_OE) else $error("drive during pullup");
   a_pullup_hold: assert property (
      STRONG_PULLUP_REQ && low_n < C_RESET - 4 |=> STRONG_PULLUP_REQ)
      else $error("pullup request dropped");
   a_long_abort: assert property (
      s_long_low |-> !DQ_OE && !STRONG_PULLUP_REQ) else $error("no abort on long low");
   a_rx_stall: assert property (
      s_rx_wait |=> RX_VALID && $stable(RX_BYTE)) else $error("stalled byte lost");
endmodule
bind swl_link swl_link_assertions i_swl_link_assertions (.CLK(CLK), .SRST(SRST),
   .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .STRONG_PULLUP_REQ(STRONG_PULLUP_REQ),
   .RX_BYTE(RX_BYTE), .RX_VALID(RX_VALID), .RX_READY(RX_READY));

// ---- dv/swl_master_model.sv ----
// swl_master_model: bus master that times every slot and reset pulse
// assumes dq is the resolved wire with a pull-up
`timescale 1ns/1ps
module swl_master_model
   import swl_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic dq, // resolved line level
   output logic master_low // high while the master pulls
);
   localparam int US = CLK_MHZ;
   initial master_low = 1'b0;
   // one slot: low, release, sample, then 60 us slot plus 1 us recovery
   task automatic slot(input int lo, input int smp, output logic v);
      master_low <= 1'b1;
      repeat (lo) @(posedge clk);
      master_low <= 1'b0;
      repeat (smp - lo) @(posedge clk);
      v = dq;
      repeat (61 * US - smp) @(posedge clk);
   endtask
   task automatic wr_byte(input logic [7:0] b);
      logic v;
      for (int i = 0; i < 8; i++) begin
         slot(b[i] ? US : 60 * US, b[i] ? US : 60 * US, v);
      end
   endtask
   // early sample keeps inside the device's valid window
   task automatic rd_byte(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         slot(US, 10 * US, b[i]);
      end
   endtask
   task automatic bus_reset(output int pd_at, output int pd_len);
      pd_at = 0;
      pd_len = 0;
      master_low <= 1'b1;
      repeat (C_RESET + 10) @(posedge clk);
      master_low <= 1'b0;
      @(posedge clk);
      while (dq && pd_at < 70 * US) begin
         @(posedge clk);
         pd_at++;
      end
      while (!dq && pd_len < 250 * US) begin
         @(posedge clk);
         pd_len++;
      end
      repeat (US) @(posedge clk);
   endtask
endmodule

// ---- dv/swl_link_tb.sv ----
// swl_link_tb: scenario bench for the sensor link slave
// assumes the master model times slots; the wire is pulled up
`timescale 1ns/1ps
module swl_link_tb;
   import swl_pkg::*;
   logic CLK = 1'b0, SRST = 1'b1, RX_READY = 1'b0;
   logic DQ_IN, DQ_OE, DQ_OUT, STRONG_PULLUP_REQ, RX_VALID, m_low;
   logic [7:0] RX_BYTE, b;
   int failures = 0, checks = 0, cyc = 0, pd_at, pd_len;
   assign DQ_IN = !(m_low || (DQ_OE && !DQ_OUT)); // pull-up when nobody pulls
   always #2 CLK = ~CLK;
   swl_link i_swl_link (.CLK(CLK), .SRST(SRST), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT),
      .DQ_OE(DQ_OE), .STRONG_PULLUP_REQ(STRONG_PULLUP_REQ), .RX_BYTE(RX_BYTE),
      .RX_VALID(RX_VALID), .RX_READY(RX_READY));
   swl_master_model i_swl_master_model (.clk(CLK), .dq(DQ_IN), .master_low(m_low));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // hang guard, sized for about 5.5 million cycles of slots
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 7000000) begin
         failures++;
         finish_test();
      end
   end
   task automatic open_link(input logic [7:0] addr);
      logic ok;
      i_swl_master_model.bus_reset(pd_at, pd_len);
      ok = pd_at >= 15 * CLK_MHZ && pd_at <= 60 * CLK_MHZ;
      ok = ok && pd_len >= 60 * CLK_MHZ && pd_len <= 240 * CLK_MHZ;
      check("presence", 8'h01, {7'h00, ok});
      i_swl_master_model.wr_byte(addr);
   endtask
   // consumer stalls through all three bytes, so the buffer must hold them
   task automatic t_store(input logic [7:0] th, input logic [7:0] tl, input logic [7:0] cf);
      open_link(CMD_SKIP_ADDR);
      i_swl_master_model.wr_byte(CMD_STORE);
      i_swl_master_model.wr_byte(th);
      i_swl_master_model.wr_byte(tl);
      i_swl_master_model.wr_byte(cf);
      check("rx first", th, RX_BYTE);
      check("rx valid", 8'h01, {7'h00, RX_VALID});
      RX_READY <= 1'b1;
      @(posedge CLK);
      RX_READY <= 1'b0;
      repeat (3) @(posedge CLK);
      check("rx second", tl, RX_BYTE);
      RX_READY <= 1'b1;
      @(posedge CLK);
      RX_READY <= 1'b0;
      repeat (3) @(posedge CLK);
      check("rx third", cf, RX_BYTE);
      RX_READY <= 1'b1;
      repeat (2) @(posedge CLK);
      RX_READY <= 1'b0;
   endtask
   // reads five of nine bytes; the next reset aborts the rest
   task automatic t_dump(input logic [7:0] th, input logic [7:0] tl, input logic [7:0] cf);
      logic [7:0] exp [5];
      exp = '{TEMP_LSB_RST, TEMP_MSB_RST, th, tl, cf};
      open_link(CMD_SKIP_ADDR);
      i_swl_master_model.wr_byte(CMD_DUMP);
      for (int i = 0; i < 5; i++) begin
         i_swl_master_model.rd_byte(b);
         check("dump byte", exp[i], b);
      end
   endtask
   task automatic t_save_reload(input logic reload);
      logic v;
      open_link(CMD_SKIP_ADDR);
      i_swl_master_model.wr_byte(reload ? CMD_RELOAD : CMD_SAVE);
      if (reload) begin
         i_swl_master_model.slot(CLK_MHZ, 10 * CLK_MHZ, v);
         check("reload status", 8'h01, {7'h00, v});
      end else begin
         repeat (10) @(posedge CLK);
         check("pullup", 8'h01, {7'h00, STRONG_PULLUP_REQ});
      end
   endtask
   task automatic t_refused(input logic [7:0] addr, input logic [7:0] cmd);
      open_link(addr);
      i_swl_master_model.wr_byte(cmd);
      i_swl_master_model.rd_byte(b);
      check("released line", 8'hFF, b);
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      SRST <= 1'b0;
      repeat (80) @(posedge CLK);
      t_store(8'h3C, 8'hA5, 8'h1F);
      t_save_reload(1'b0);
      t_store(8'h00, 8'hFF, 8'h5A);
      t_dump(8'h00, 8'hFF, 8'h5A);
      t_save_reload(1'b1);
      t_dump(8'h3C, 8'hA5, 8'h1F);
      t_refused(8'h33, CMD_DUMP);
      t_refused(CMD_SKIP_ADDR, 8'h00);
      finish_test();
   end
endmodule
